// >>> design/interrupt_group_aggregator.sv
// Top: serial-bus result and power-management/DMA group source, enable and result
`timescale 1ns/100ps
module interrupt_group_aggregator #(
   parameter int DMA_CHANNELS = 8                                  // DMA channels served
) (
   input  wire logic                                 MCLK_I,      // 50 MHz clock
   input  wire logic                                 RSTN_I,      // System reset, active low
   input  wire logic [irq_group_pkg::ADDR_W-1:0]     ADDR_I,      // Peripheral bus address
   input  wire logic                                 WR_I,        // Write strobe
   input  wire logic                                 RD_I,        // Read strobe
   input  wire logic [irq_group_pkg::DATA_W-1:0]     WDATA_I,     // Write data
   input  wire logic [irq_group_pkg::DATA_W-1:0]     SERIAL_STATUS_I, // Serial group source&enable
   input  wire logic                                 PM_CTL2_WR_I,    // Host wrote control two
   input  wire logic                                 PM_EN2_WR_I,     // Host wrote enable two
   input  wire logic                                 PM_STS2_WR_I,    // Host wrote status two
   input  wire logic [DMA_CHANNELS-1:0]              DMA_DONE_I,      // Channel requests
   output logic      [irq_group_pkg::DATA_W-1:0]     RDATA_O,     // Registered read data
   output logic                                      SERIAL_IRQ_O,// Serial group interrupt
   output logic                                      PMDMA_IRQ_O  // Pm/DMA group interrupt
);
   import irq_group_pkg::*;

   // Register map on the controller peripheral bus (byte offsets):
   //   0x58  serial-bus group result: bits 17:0 follow the outside source/enable AND
   //   0x64  pm/DMA group source: sticky event bits, write one to clear
   //   0x68  pm/DMA group enable: plain read-write on the live bits
   //   0x6C  pm/DMA group result: source AND enable, bit 31 read-write helper
   // Limitation: the serial-bus group's source and enable live outside this block

   // Channel count must fill the channel field exactly; a shorter vector would
   // leave source bits that no event can ever set
   if (DMA_CHANNELS != DMA_TOP_BIT - DMA_LOW_BIT + 1) begin : g_chk_channels
      $error("DMA_CHANNELS must equal the width of the channel field");
   end

   // Result views and masks are laid out for one 32-bit register word
   if (DATA_W != 32) begin : g_chk_width
      $error("DATA_W must be 32");
   end

   // Every register offset must be reachable on the address bus
   if (ADDR_W < 8) begin : g_chk_addr
      $error("ADDR_W too narrow for the register offsets");
   end

   // Channel bits must sit above the host-write bits, or the two would overlap
   if (DMA_LOW_BIT <= PM_STS2_BIT) begin : g_chk_fields
      $error("Channel field overlaps the host-write bits");
   end

   // The helper bit must stay out of the live source bits, or a write to the
   // result register could raise the group output
   if (SOURCE_LIVE_MASK[HELPER_BIT] != 1'b0) begin : g_chk_helper
      $error("Helper bit overlaps a live source bit");
   end

   // The serial-bus live field must leave the helper bit free as well
   if (SERIAL_LIVE_MASK[HELPER_BIT] != 1'b0) begin : g_chk_serial
      $error("Helper bit overlaps a serial-bus source bit");
   end

   // Event and register state
   logic [DATA_W-1:0] set_vec;              // Event bits raised this cycle
   logic [DATA_W-1:0] clear_vec;            // Source bits software clears this cycle
   logic [DATA_W-1:0] source;               // Sticky source register
   logic [DATA_W-1:0] next_source;          // Next source value
   logic [DATA_W-1:0] enable;               // Enable register
   logic [DATA_W-1:0] next_enable;          // Next enable value
   logic              helper_pm;            // Pm/DMA normalize helper bit
   logic              next_helper_pm;       // Next pm/DMA helper bit
   logic              helper_sb;            // Serial-bus normalize helper bit
   logic              next_helper_sb;       // Next serial-bus helper bit

   // Decoded strobes and views
   logic              wr_source;            // Write to the source register
   logic              wr_enable;            // Write to the enable register
   logic              wr_result_pm;         // Write to the pm/DMA result register
   logic              wr_result_sb;         // Write to the serial-bus result register
   logic              rd_source;            // Read of the source register
   logic              rd_enable;            // Read of the enable register
   logic              rd_result_pm;         // Read of the pm/DMA result register
   logic              rd_result_sb;         // Read of the serial-bus result register
   wire  [DATA_W-1:0] result_pm;            // Pm/DMA result view
   wire  [DATA_W-1:0] result_sb;            // Serial-bus result view
   logic [DATA_W-1:0] next_rdata;           // Read mux output
   logic              next_pm_irq;          // Next group output
   logic              next_sb_irq;          // Next serial output

   // Address decode shared by the write and read paths
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // Request test over bits 30:0; the helper bit carries no event and is left out
   function automatic logic any_request(input logic [DATA_W-1:0] view);
      any_request = |(view & IRQ_LOW_MASK);
   endfunction : any_request

   // Event mapper: places host writes and channel completions at their source bits
   irq_event_map #(.DMA_CHANNELS(DMA_CHANNELS)) u_map (
      .pm_control_two_written_i (PM_CTL2_WR_I),
      .pm_enable_two_written_i  (PM_EN2_WR_I),
      .pm_status_two_written_i  (PM_STS2_WR_I),
      .dma_done_i               (DMA_DONE_I),
      .set_vec_o                (set_vec)
   );

   // Result views, one generated bit per source position; a result bit follows
   // its source and enable bits with no clock in between
   for (genvar b = 0; b < HELPER_BIT; b++) begin : g_result
      assign result_pm[b] = source[b] & enable[b];
      assign result_sb[b] = SERIAL_STATUS_I[b] & SERIAL_LIVE_MASK[b];
   end
   // Bit 31 is the helper bit, never an event
   assign result_pm[HELPER_BIT] = helper_pm;
   assign result_sb[HELPER_BIT] = helper_sb;

   // Bus decode; an unmapped address selects nothing, so its write is dropped
   always_comb begin
      wr_source    = WR_I && hit(ADDR_I, PMDMA_SOURCE_OFS);
      wr_enable    = WR_I && hit(ADDR_I, PMDMA_ENABLE_OFS);
      wr_result_pm = WR_I && hit(ADDR_I, PMDMA_RESULT_OFS);
      wr_result_sb = WR_I && hit(ADDR_I, SERIAL_RESULT_OFS);
      rd_source    = RD_I && hit(ADDR_I, PMDMA_SOURCE_OFS);
      rd_enable    = RD_I && hit(ADDR_I, PMDMA_ENABLE_OFS);
      rd_result_pm = RD_I && hit(ADDR_I, PMDMA_RESULT_OFS);
      rd_result_sb = RD_I && hit(ADDR_I, SERIAL_RESULT_OFS);
      clear_vec    = REG_RESET;
      if (wr_source) begin
         // Reserved bits ignore the write, only live bits are cleared
         clear_vec = WDATA_I & SOURCE_LIVE_MASK;
      end
   end

   // Source and enable next values; a hardware set wins over a same-cycle clear,
   // so an event that lands while software acknowledges the last one is kept
   always_comb begin
      next_source = (source & ~clear_vec) | set_vec;
      next_source = next_source & SOURCE_LIVE_MASK;
      next_enable = enable;
      if (wr_enable) begin
         next_enable = WDATA_I & SOURCE_LIVE_MASK;
      end
   end

   // Source and enable registers, cleared by the system reset
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         source <= REG_RESET;
         enable <= REG_RESET;
      end else begin
         source <= next_source;
         enable <= next_enable;
      end
   end

   // Helper bits keep bit 31 of the last word software wrote to their result register; they never raise an output
   always_comb begin
      next_helper_pm = helper_pm;
      next_helper_sb = helper_sb;
      if (wr_result_pm) begin
         next_helper_pm = WDATA_I[HELPER_BIT];
      end
      if (wr_result_sb) begin
         next_helper_sb = WDATA_I[HELPER_BIT];
      end
   end

   // Helper bit registers
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         helper_pm <= REG_RESET[HELPER_BIT];
         helper_sb <= REG_RESET[HELPER_BIT];
      end else begin
         helper_pm <= next_helper_pm;
         helper_sb <= next_helper_sb;
      end
   end

   // Read mux and interrupt levels; a read sees the state before any write of the
   // same cycle, and an idle or unmapped read returns zero
   always_comb begin
      next_rdata = REG_RESET;
      if (rd_source) begin
         next_rdata = source;
      end else if (rd_enable) begin
         next_rdata = enable;
      end else if (rd_result_pm) begin
         next_rdata = result_pm;
      end else if (rd_result_sb) begin
         next_rdata = result_sb;
      end else begin
         // Unmapped address or no read at all
         next_rdata = REG_RESET;
      end
      next_pm_irq = any_request(result_pm);
      next_sb_irq = any_request(result_sb);
   end

   // Output registers; the interrupt levels lag the state by one cycle, which
   // keeps every output straight from a flip-flop
   always_ff @(posedge MCLK_I) begin
      if (!RSTN_I) begin
         RDATA_O      <= REG_RESET;
         PMDMA_IRQ_O  <= REG_RESET[0];
         SERIAL_IRQ_O <= REG_RESET[0];
      end else begin
         RDATA_O      <= next_rdata;
         PMDMA_IRQ_O  <= next_pm_irq;
         SERIAL_IRQ_O <= next_sb_irq;
      end
   end
endmodule : interrupt_group_aggregator

// >>> design/irq_event_map.sv
// Event mapper: gathers per-source requests into one source-set vector
`timescale 1ns/100ps
module irq_event_map #(
   parameter int DMA_CHANNELS = 8                                 // DMA channels served
) (
   input  wire logic                      pm_control_two_written_i, // Host write pulse
   input  wire logic                      pm_enable_two_written_i,  // Host write pulse
   input  wire logic                      pm_status_two_written_i,  // Host write pulse
   input  wire logic [DMA_CHANNELS-1:0]   dma_done_i,               // Channel completions
   output logic      [31:0]               set_vec_o                 // Bits to set
);
   import irq_group_pkg::*;

   // Channel count must exactly fill the documented bit field
   if (DMA_CHANNELS != DMA_TOP_BIT - DMA_LOW_BIT + 1) begin : g_chk
      $error("DMA_CHANNELS must match the channel field");
   end

   // Place every event at its source bit; reserved bits stay zero
   always_comb begin
      set_vec_o              = REG_RESET;
      set_vec_o[PM_CTL2_BIT] = pm_control_two_written_i;
      set_vec_o[PM_EN2_BIT]  = pm_enable_two_written_i;
      set_vec_o[PM_STS2_BIT] = pm_status_two_written_i;
      for (int ch = 0; ch < DMA_CHANNELS; ch++) begin
         set_vec_o[DMA_TOP_BIT - ch] = dma_done_i[ch];
      end
   end
endmodule : irq_event_map

// >>> design/irq_group_pkg.sv
// Package: register offsets, bit positions and reset values of the interrupt group slice
package irq_group_pkg;
   localparam int          DATA_W            = 32;               // Register width
   localparam int          ADDR_W            = 8;                // Byte address width
   localparam logic [7:0]  SERIAL_RESULT_OFS = 8'h58;            // Serial-bus group result
   localparam logic [7:0]  PMDMA_SOURCE_OFS  = 8'h64;            // Group source
   localparam logic [7:0]  PMDMA_ENABLE_OFS  = 8'h68;            // Group enable
   localparam logic [7:0]  PMDMA_RESULT_OFS  = 8'h6C;            // Group result
   localparam logic [31:0] REG_RESET         = 32'h0000_0000;    // Reset value of all registers
   localparam int          PM_CTL2_BIT       = 0;                // Control-two write event
   localparam int          PM_EN2_BIT        = 1;                // Enable-two write event
   localparam int          PM_STS2_BIT       = 2;                // Status-two write event
   localparam int          DMA_TOP_BIT       = 23;               // Channel 0 position
   localparam int          DMA_LOW_BIT       = 16;               // Channel 7 position
   localparam int          HELPER_BIT        = 31;               // Normalize helper bit
   localparam logic [31:0] SOURCE_LIVE_MASK  = 32'h00FF_0007;    // Non-reserved bits
   localparam logic [31:0] SERIAL_LIVE_MASK  = 32'h0003_FFFF;    // Serial-bus group bits 17:0
   localparam logic [31:0] IRQ_LOW_MASK      = 32'h7FFF_FFFF;    // Result bits 30:0
endpackage : irq_group_pkg

// >>> verif/interrupt_group_aggregator_assertions.sv
// Checker: bus and interrupt relations of the group slice
`timescale 1ns/100ps
module irq_group_checker (
   input  wire logic        MCLK_I,          // Clock
   input  wire logic        RSTN_I,          // Reset, active low
   input  wire logic [7:0]  ADDR_I,          // Address
   input  wire logic        WR_I,            // Write strobe
   input  wire logic        RD_I,            // Read strobe
   input  wire logic [31:0] WDATA_I,         // Write data
   input  wire logic [31:0] SERIAL_STATUS_I, // Serial group status
   input  wire logic        PM_CTL2_WR_I,    // Control-two event
   input  wire logic        PM_EN2_WR_I,     // Enable-two event
   input  wire logic        PM_STS2_WR_I,    // Status-two event
   input  wire logic [7:0]  DMA_DONE_I,      // Channel requests
   input  wire logic [31:0] RDATA_O,         // Read data
   input  wire logic        SERIAL_IRQ_O,    // Serial interrupt
   input  wire logic        PMDMA_IRQ_O      // Group interrupt
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);
   // Decoded reads and the source-register write, so the properties stay short
   wire r58 = RD_I && ADDR_I == 8'h58;
   wire r64 = RD_I && ADDR_I == 8'h64;
   wire r68 = RD_I && ADDR_I == 8'h68;
   wire r6c = RD_I && ADDR_I == 8'h6C;
   wire w64 = WR_I && ADDR_I == 8'h64;
   a_ctl2_sets_bit: assert property (PM_CTL2_WR_I ##1 r64 |=> RDATA_O[0])
      else $error("control-two event lost");
   a_en2_sets_bit: assert property (PM_EN2_WR_I ##1 r64 |=> RDATA_O[1])
      else $error("enable-two event lost");
   a_sts2_sets_bit: assert property (PM_STS2_WR_I ##1 r64 |=> RDATA_O[2])
      else $error("status-two event lost");
   a_dma_zero_map: assert property (DMA_DONE_I[0] ##1 r64 |=> RDATA_O[23])
      else $error("channel 0 not at bit 23");
   a_reserved_reads_zero: assert property (r64 |=> (RDATA_O & 32'hFF00_FFF8) == 32'h0)
      else $error("reserved source bit set");
   a_write_clears_bit: assert property (w64 && WDATA_I[0] && !PM_CTL2_WR_I ##1 r64
      |=> !RDATA_O[0]) else $error("source bit not cleared");
   a_enable_stores_word: assert property (WR_I && ADDR_I == 8'h68 ##1 r68
      |=> RDATA_O == ($past(WDATA_I, 2) & 32'h00FF_0007)) else $error("enable readback");
   a_normalize_helper_bit_bit_stores: assert property (WR_I && ADDR_I == 8'h6C ##1 r6c
      |=> RDATA_O[31] == $past(WDATA_I[31], 2)) else $error("normalize bit readback");
   a_serial_result_map: assert property (r58
      |=> RDATA_O[30:0] == ($past(SERIAL_STATUS_I[30:0]) & 31'h3FFFF)) else $error("serial");
   a_group_irq_level: assert property (r6c |=> PMDMA_IRQ_O == |RDATA_O[30:0])
      else $error("group interrupt level");
   a_serial_irq_level: assert property (r58 |=> SERIAL_IRQ_O == |RDATA_O[30:0])
      else $error("serial interrupt level");
endmodule : irq_group_checker

// >>> verif/interrupt_group_aggregator_tb.sv
// Bench: random bus traffic and events against a behavioural model
`timescale 1ns/100ps
module interrupt_group_aggregator_tb;
   import irq_group_pkg::*;
   logic        mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, n12 = 1'b0, n13 = 1'b0;
   logic        sirq, pirq, exp_s, exp_p;              // Interrupts seen and expected
   logic [2:0]  pm = 3'h0;                              // Host write events
   logic [7:0]  addr = 8'h00, dma = 8'h00;
   logic [31:0] wd = 32'h0, ser = 32'h0, src = 32'h0, en = 32'h0, rdata, exp_rd, r;
   int          mismatches = 0, samples_checked = 0;
   always #10 mclk = ~mclk;
   interrupt_group_aggregator dut (.MCLK_I(mclk), .RSTN_I(rstn), .ADDR_I(addr), .WR_I(wr),
      .RD_I(rd), .WDATA_I(wd), .SERIAL_STATUS_I(ser), .PM_CTL2_WR_I(pm[0]), .PM_EN2_WR_I(pm[1]),
      .PM_STS2_WR_I(pm[2]), .DMA_DONE_I(dma), .RDATA_O(rdata), .SERIAL_IRQ_O(sirq),
      .PMDMA_IRQ_O(pirq));
   // Maximal-length shift register, so the traffic repeats the same way every run
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (mismatches == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   // One cycle: model steps on the rising edge, outputs compared at the falling edge
   task automatic step();
      logic [31:0] ev;
      @(posedge mclk);
      ev = {29'h0, pm};
      for (int c = 0; c < 8; c++) ev[23-c] = dma[c];
      exp_rd = 32'h0;
      if (rd && addr == PMDMA_SOURCE_OFS) exp_rd = src;
      if (rd && addr == PMDMA_ENABLE_OFS) exp_rd = en;
      if (rd && addr == PMDMA_RESULT_OFS) exp_rd = {n13, src[30:0] & en[30:0]};
      if (rd && addr == SERIAL_RESULT_OFS) exp_rd = {n12, 13'h0, ser[17:0]};
      exp_p = |(src[30:0] & en[30:0]);
      exp_s = |ser[17:0];
      if (wr && addr == PMDMA_SOURCE_OFS) src = src & ~wd;
      src = (src | ev) & SOURCE_LIVE_MASK;
      if (wr && addr == PMDMA_ENABLE_OFS) en = wd & SOURCE_LIVE_MASK;
      if (wr && addr == PMDMA_RESULT_OFS) n13 = wd[31];
      if (wr && addr == SERIAL_RESULT_OFS) n12 = wd[31];
      if (!rstn) {src, en, n12, n13, exp_rd, exp_s, exp_p} = '0;
      @(negedge mclk);
      check("read data", rdata, exp_rd);
      check("interrupts", 32'({sirq, pirq}), 32'({exp_s, exp_p}));
   endtask : step
   initial begin
      r = 32'h5B;
      repeat (10) step();
      // Mixed traffic with a second reset in mid-run
      for (int i = 0; i < 3000; i++) begin
         r = lfsr(r);
         rstn = !(i >= 1500 && i < 1503);
         wr = r[0];
         rd = r[1];
         addr = (r[4] & r[5]) ? 8'h70 : (r[3:2] == 2'd3) ? 8'h58 : 8'h64 + 8'(r[3:2]) * 8'h04;
         wd = {r[7:0], r[31:8]};
         ser = {r[15:0], r[31:16]};
         pm = r[10:8] & r[13:11] & r[16:14];
         dma = r[23:16] & r[31:24];
         step();
      end
      print_verdict();
   end
endmodule : interrupt_group_aggregator_tb
bind interrupt_group_aggregator irq_group_checker chk (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
   .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .PM_CTL2_WR_I(PM_CTL2_WR_I),
   .PM_EN2_WR_I(PM_EN2_WR_I), .PM_STS2_WR_I(PM_STS2_WR_I),
   .SERIAL_STATUS_I(SERIAL_STATUS_I), .DMA_DONE_I(DMA_DONE_I), .RDATA_O(RDATA_O),
   .SERIAL_IRQ_O(SERIAL_IRQ_O), .PMDMA_IRQ_O(PMDMA_IRQ_O));
